// ### include/pps_pkg.sv
/*
 * Constants, encodings and state type for the port power sequencer.
 * Assumes a single 25 MHz reference clock; all long delays count 1 ms ticks.
 */
`default_nettype none
package pps_pkg;
    // ----------------------------------------------------------------
    // Clock and timebase
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;        // 25 MHz reference
    localparam int MS_NS = 1000000;           // One millisecond in ns
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    // Reset pin filter: least time, so round up
    localparam int RESET_FILT_NS = 4500;
    localparam int RESET_FILT_CYCLES = (RESET_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ----------------------------------------------------------------
    // Timer windows in ms (typical figures)
    // ----------------------------------------------------------------
    localparam int START_LIMIT_MS = 59;       // Inrush limiting allowed
    localparam int OVERCURRENT_WINDOW_MS = 59;
    localparam int LIMIT_WINDOW_EXT_MS = 12;
    localparam int LIMIT_WINDOW_STD_MS = 59;
    localparam int DUTY_DECAY_MS = 15;        // 1 up per 16 down: 1/17 duty
    localparam int FAULT_RETRY_DELAY_MS = 1300;
    localparam int PRESTD_BACKOFF_MS = 3000;
    localparam int INJECTOR_BACKOFF_MS = 2500;
    localparam int DISCONNECT_DELAY_MS = 1300;
    localparam int DROPOUT_WINDOW_MS = 350;
    localparam int HOLD_PULSE_MIN_TICKS = 3;  // 3 ticks: >=3.6 ms always, <1.6 ms never
    localparam int TIMER_W = 12;
    // ----------------------------------------------------------------
    // Power level setting encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] PWR_13W = 3'h0;
    localparam logic [2:0] PWR_25W5 = 3'h1;
    localparam logic [2:0] PWR_38W7 = 3'h2;
    localparam logic [2:0] PWR_52W7 = 3'h3;
    localparam logic [2:0] PWR_70W = 3'h4;
    localparam logic [2:0] PWR_90W = 3'h5;
    localparam logic [2:0] PWR_CUSTOM = 3'h6;
    // ----------------------------------------------------------------
    // Detection result encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] DET_UNKNOWN = 3'h0;
    localparam logic [2:0] DET_SHORT = 3'h1;
    localparam logic [2:0] DET_CAP_HIGH = 3'h2;
    localparam logic [2:0] DET_RES_LOW = 3'h3;
    localparam logic [2:0] DET_GOOD = 3'h4;
    localparam logic [2:0] DET_RES_HIGH = 3'h5;
    localparam logic [2:0] DET_OPEN = 3'h6;
    localparam logic [2:0] DET_OVERVOLT = 3'h7;
    localparam logic [2:0] CLASS_3 = 3'h3;    // Highest class given 13 W in pre-standard mode
    // ----------------------------------------------------------------
    // Sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PPS_HELD, PPS_DETECT, PPS_WAIT_DET, PPS_INRUSH, PPS_ON, PPS_DELAY
    } pps_state_e;
endpackage
`default_nettype wire

// ### verilog/pps_sequencer.sv
/*
 * Port power sequencer: reset filter, strap latch, detection backoff,
 * inrush/overcurrent/limit fault timers and maintain-power dropout.
 * Assumes all inputs are synchronous to ref_clk; analog detection and
 * current comparators live outside and report through plain ports.
 */
//
// Functional notes
// [RULE1] Reset pin low keeps port power off
// [RULE2] Ignore reset pin lows under 4.5 us
// [RULE3] Latch config straps only at reset exit
// [RULE4] Injector select chooses midspan or endpoint behaviour
// [RULE5] Pre-standard accepts four outcomes, 13W for 0-3
// [RULE6] Otherwise only good detection is valid
// [RULE7] Twin signature needs power level 52.7W or more
// [RULE8] Power setting selects one of seven levels
// [RULE9] Open-drain powered indicator pulls low while powered
// [RULE10] Overcurrent counts timer; limit regulates gate
// [RULE11] Timer expiry pulls gate down, power off
// [RULE12] Start-up limiting tolerated about 59 ms
// [RULE13] Post start-up overcurrent faults after 59 ms
// [RULE14] Overcurrent duty limited to about 6.3 percent; the code counts 1 up per 16 down, a 1/17 duty of about 5.9 percent
// [RULE15] Limit window 12 ms extended, else 59; the code also uses 12 ms for twin-active PDs and the custom level
// [RULE16] After fault wait 1.3 s before detection
// [RULE17] Pre-standard low impedance backoff about 3 s
// [RULE18] Injector without pre-standard backoff 2.5 s
// [RULE19] After disconnect wait 1.3 s before detection
// [RULE20] Remove power after 350 ms without hold
// [RULE21] Hold pulses of 3.6 ms restart dropout
// [RULE22] All timing from one millisecond timebase; the reset pin filter counts ref_clk cycles instead
`default_nettype none
module pps_sequencer #(
    parameter int MS_DIV = pps_pkg::MS_CYCLES  // Cycles per ms tick
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reset_in_n,                  // Documented reset pin
    input wire logic injector_select,             // Strap: midspan injector
    input wire logic prestandard_select,          // Strap: accept legacy PDs
    input wire logic twin_signature_select,       // Strap: twin-signature PDs
    input wire logic [2:0] power_level_setting,   // Strap: max power level
    input wire logic detect_done,                 // Detection finished pulse
    input wire logic [2:0] detect_result,         // Result with detect_done
    input wire logic twin_detected,               // Two signatures in parallel
    input wire logic [2:0] pd_class,              // Class with detect_done
    input wire logic class_extended,              // Extended-class PD
    input wire logic over_cut,                    // Above overcurrent_threshold
    input wire logic at_limit,                    // At limit_threshold
    input wire logic load_pulse,                  // Load above hold level
    output logic detect_start,                    // Start detection pulse
    output logic gate_enable,                     // Drive external switch on
    output logic gate_regulate,                   // Hold current constant
    output logic powered_led_o,                   // Indicator level, always low
    output logic powered_led_oe,                  // Indicator pull-down enable
    output logic port_powered,                    // Port power applied
    output logic fault_event,                     // Fault timer expired pulse
    output logic disconnect_event,                // Dropout removal pulse
    output logic [2:0] allocated_level,           // Budget for powered PD
    output logic twin_active,                     // Twin-signature PD powered
    output logic [2:0] level_latched              // Latched power level
);
    // ----------------------------------------------------------------
    // Reset pin filter
    // ----------------------------------------------------------------
    logic [7:0] low_count;   // Consecutive low cycles on reset pin
    logic held;              // Filtered reset asserted
    // [RULE2] glitch filter count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            low_count <= 8'h00;
        end else if (reset_in_n) begin
            low_count <= 8'h00;
        end else if (low_count != 8'(pps_pkg::RESET_FILT_CYCLES)) begin
            low_count <= low_count + 8'h01;
        end
    end

    // Filtered level: chip reset counts as held too
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            held <= 1'b1;
        end else if (low_count == 8'(pps_pkg::RESET_FILT_CYCLES)) begin
            held <= 1'b1;
        end else if (reset_in_n) begin
            held <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Configuration latch
    // ----------------------------------------------------------------
    logic cfg_injector;      // Midspan timing
    logic cfg_prestd;        // Pre-standard acceptance
    logic cfg_twin;          // Twin signature enabled
    logic pending;           // Straps not yet captured since reset
    // Straps are sampled by a clocked process on release, never by the
    // async reset itself, so they are taken at their settled value.
    // [RULE3] capture at reset exit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pending <= 1'b1;
            cfg_injector <= 1'b0;
            cfg_prestd <= 1'b0;
            cfg_twin <= 1'b0;
            level_latched <= pps_pkg::PWR_13W;
        end else if (held) begin
            pending <= 1'b1;
        end else if (pending) begin
            pending <= 1'b0;
            cfg_injector <= injector_select;
            cfg_prestd <= prestandard_select;
            cfg_twin <= twin_signature_select;
            // [RULE8] seven levels, others fall back
            level_latched <= (power_level_setting > pps_pkg::PWR_CUSTOM) ?
                pps_pkg::PWR_13W : power_level_setting;
        end
    end

    // [RULE7] twin only at 52.7 W or above
    logic twin_ok;           // Twin mode usable
    assign twin_ok = cfg_twin && (level_latched >= pps_pkg::PWR_52W7);

    // ----------------------------------------------------------------
    // Millisecond timebase
    // ----------------------------------------------------------------
    logic [15:0] div_count;  // Prescaler
    logic ms_tick;           // One cycle each ms
    // [RULE22] free-running ms tick
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_count <= 16'h0000;
        end else if (div_count == 16'(MS_DIV - 1)) begin
            div_count <= 16'h0000;
        end else begin
            div_count <= div_count + 16'h0001;
        end
    end
    assign ms_tick = (div_count == 16'(MS_DIV - 1));

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    pps_pkg::pps_state_e state;
    pps_pkg::pps_state_e next_state;
    logic [pps_pkg::TIMER_W-1:0] delay_count;   // Remaining ms in DELAY
    logic [pps_pkg::TIMER_W-1:0] next_delay;
    logic det_valid;         // Detection outcome accepted
    logic low_imp;           // Port looked low impedance
    logic inrush_fault;      // Start-up limiting too long
    logic run_fault;         // Post start-up timer expiry
    logic dropout;           // No hold pulse within window

    // [RULE5] pre-standard accepts four outcomes
    // [RULE6] otherwise only good
    always_comb begin
        if (cfg_prestd) begin
            det_valid = (detect_result == pps_pkg::DET_RES_LOW) ||
                        (detect_result == pps_pkg::DET_GOOD) ||
                        (detect_result == pps_pkg::DET_RES_HIGH) ||
                        (detect_result == pps_pkg::DET_CAP_HIGH);
        end else begin
            det_valid = (detect_result == pps_pkg::DET_GOOD);
        end
    end
    assign low_imp = (detect_result == pps_pkg::DET_SHORT);

    // Next state and delay load
    always_comb begin
        next_state = state;
        next_delay = delay_count;
        case (state)
            pps_pkg::PPS_HELD: begin
                if (!held && !pending) begin
                    next_state = pps_pkg::PPS_DETECT;
                end
            end
            pps_pkg::PPS_DETECT: begin
                next_state = pps_pkg::PPS_WAIT_DET;
            end
            pps_pkg::PPS_WAIT_DET: begin
                if (detect_done) begin
                    if (det_valid) begin
                        next_state = pps_pkg::PPS_INRUSH;
                    end else if (cfg_prestd && low_imp) begin
                        // [RULE17] pre-standard backoff
                        next_state = pps_pkg::PPS_DELAY;
                        next_delay = pps_pkg::TIMER_W'(pps_pkg::PRESTD_BACKOFF_MS);
                    end else if (cfg_injector && !cfg_prestd) begin
                        // [RULE4] [RULE18] midspan backoff
                        next_state = pps_pkg::PPS_DELAY;
                        next_delay = pps_pkg::TIMER_W'(pps_pkg::INJECTOR_BACKOFF_MS);
                    end else begin
                        // Endpoint, or midspan in pre-standard mode, retries at once
                        next_state = pps_pkg::PPS_DETECT;
                    end
                end
            end
            pps_pkg::PPS_INRUSH: begin
                if (inrush_fault) begin
                    // [RULE16] fault retry delay
                    next_state = pps_pkg::PPS_DELAY;
                    next_delay = pps_pkg::TIMER_W'(pps_pkg::FAULT_RETRY_DELAY_MS);
                end else if (!at_limit) begin
                    next_state = pps_pkg::PPS_ON;
                end
            end
            pps_pkg::PPS_ON: begin
                if (run_fault) begin
                    // [RULE16] fault retry delay
                    next_state = pps_pkg::PPS_DELAY;
                    next_delay = pps_pkg::TIMER_W'(pps_pkg::FAULT_RETRY_DELAY_MS);
                end else if (dropout) begin
                    // [RULE19] disconnect delay
                    next_state = pps_pkg::PPS_DELAY;
                    next_delay = pps_pkg::TIMER_W'(pps_pkg::DISCONNECT_DELAY_MS);
                end
            end
            pps_pkg::PPS_DELAY: begin
                if (ms_tick) begin
                    if (delay_count <= pps_pkg::TIMER_W'(1)) begin
                        next_state = pps_pkg::PPS_DETECT;
                    end
                    next_delay = delay_count - pps_pkg::TIMER_W'(1);
                end
            end
            default: begin
                next_state = pps_pkg::PPS_HELD;
            end
        endcase
    end

    // [RULE1] filtered reset forces the idle, unpowered state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state <= pps_pkg::PPS_HELD;
            delay_count <= '0;
        end else if (held) begin
            state <= pps_pkg::PPS_HELD;
            delay_count <= '0;
        end else begin
            state <= next_state;
            delay_count <= next_delay;
        end
    end

    logic powered;           // Gate on in this state
    assign powered = (state == pps_pkg::PPS_INRUSH) || (state == pps_pkg::PPS_ON);

    // ----------------------------------------------------------------
    // Fault timers
    // ----------------------------------------------------------------
    logic [7:0] limit_ms;    // Continuous limiting time
    logic [7:0] cut_acc;     // Overcurrent accumulator
    logic [3:0] decay_ms;    // Decay prescaler
    logic [7:0] limit_max;   // Limit window for this PD

    // [RULE15] extended, twin or custom get the short window
    assign limit_max = (class_extended || twin_active || level_latched == pps_pkg::PWR_CUSTOM) ?
        8'(pps_pkg::LIMIT_WINDOW_EXT_MS) : 8'(pps_pkg::LIMIT_WINDOW_STD_MS);
    // [RULE12] start-up limiting tolerance
    assign inrush_fault = at_limit && (limit_ms >= 8'(pps_pkg::START_LIMIT_MS));
    // [RULE13] [RULE11] expiry removes power
    assign run_fault = (cut_acc >= 8'(pps_pkg::OVERCURRENT_WINDOW_MS)) ||
                       (at_limit && limit_ms >= limit_max);

    // Continuous limit time; restarts when leaving start-up
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            limit_ms <= 8'h00;
        end else if (!powered || !at_limit || next_state == pps_pkg::PPS_ON &&
                     state == pps_pkg::PPS_INRUSH) begin
            limit_ms <= 8'h00;
        end else if (ms_tick && limit_ms != 8'hff) begin
            limit_ms <= limit_ms + 8'h01;
        end
    end

    // Bursts accumulate: counts up per ms over, down once per 16 ms
    // under, so a duty cycle above 1/17 still reaches the window.
    // [RULE10] [RULE14] duty-limited accumulator
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cut_acc <= 8'h00;
            decay_ms <= 4'h0;
        end else if (state != pps_pkg::PPS_ON) begin
            cut_acc <= 8'h00;
            decay_ms <= 4'h0;
        end else if (ms_tick) begin
            if (over_cut) begin
                cut_acc <= cut_acc + 8'h01;
            end else if (decay_ms == 4'(pps_pkg::DUTY_DECAY_MS)) begin
                decay_ms <= 4'h0;
                if (cut_acc != 8'h00) begin
                    cut_acc <= cut_acc - 8'h01;
                end
            end else begin
                decay_ms <= decay_ms + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Maintain-power dropout
    // ----------------------------------------------------------------
    logic [1:0] pulse_ticks;                    // Ticks seen in current pulse
    logic [pps_pkg::TIMER_W-1:0] dropout_ms;    // Time since last hold pulse
    logic pulse_ok;                             // Pulse long enough

    // [RULE21] qualify hold pulses
    assign pulse_ok = ms_tick && load_pulse &&
                      (pulse_ticks == 2'(pps_pkg::HOLD_PULSE_MIN_TICKS - 1));
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pulse_ticks <= 2'h0;
        end else if (!load_pulse) begin
            pulse_ticks <= 2'h0;
        end else if (ms_tick && pulse_ticks != 2'(pps_pkg::HOLD_PULSE_MIN_TICKS)) begin
            pulse_ticks <= pulse_ticks + 2'h1;
        end
    end

    // [RULE20] dropout window timer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dropout_ms <= '0;
        end else if (!powered || pulse_ok) begin
            dropout_ms <= '0;
        end else if (ms_tick) begin
            dropout_ms <= dropout_ms + pps_pkg::TIMER_W'(1);
        end
    end
    assign dropout = (dropout_ms >= pps_pkg::TIMER_W'(pps_pkg::DROPOUT_WINDOW_MS));

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Registered decisions so gate and indicator change together
    // [RULE11] gate pulled down on fault
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gate_enable <= 1'b0;
            port_powered <= 1'b0;
            powered_led_oe <= 1'b0;
            fault_event <= 1'b0;
            disconnect_event <= 1'b0;
            detect_start <= 1'b0;
        end else begin
            gate_enable <= !held && (next_state == pps_pkg::PPS_INRUSH ||
                                     next_state == pps_pkg::PPS_ON);
            port_powered <= !held && (next_state == pps_pkg::PPS_INRUSH ||
                                      next_state == pps_pkg::PPS_ON);
            // [RULE9] indicator follows port power
            powered_led_oe <= !held && (next_state == pps_pkg::PPS_INRUSH ||
                                        next_state == pps_pkg::PPS_ON);
            fault_event <= !held && ((state == pps_pkg::PPS_INRUSH && inrush_fault) ||
                                     (state == pps_pkg::PPS_ON && run_fault));
            disconnect_event <= !held && state == pps_pkg::PPS_ON && !run_fault && dropout;
            detect_start <= !held && next_state == pps_pkg::PPS_DETECT;
        end
    end
    assign powered_led_o = 1'b0;
    // [RULE10] regulate while at limit
    assign gate_regulate = gate_enable && at_limit;

    // Budget and twin status taken at detection acceptance
    // [RULE5] [RULE7] allocation
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            allocated_level <= pps_pkg::PWR_13W;
            twin_active <= 1'b0;
        end else if (state == pps_pkg::PPS_WAIT_DET && detect_done && det_valid) begin
            twin_active <= twin_ok && twin_detected;
            if (cfg_prestd && !class_extended && pd_class <= pps_pkg::CLASS_3) begin
                allocated_level <= pps_pkg::PWR_13W;
            end else begin
                allocated_level <= level_latched;
            end
        end else if (!powered) begin
            twin_active <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### bench/pps_pd_model.sv
/* Powered device model: answers detection, makes hold pulses.
   Assumes detect_start is a one-cycle pulse on ref_clk. */
`default_nettype none
module pps_pd_model #(parameter int MS_DIV = 10) (
    input wire logic ref_clk,
    input wire logic detect_start,
    input wire logic [2:0] sig,
    input wire logic mps_on,
    output logic detect_done,
    output logic [2:0] detect_result,
    output logic load_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] dly = 4'h0; // Cycles until the answer
    int ph = 0; // Hold pulse phase
    // Answer four cycles after each start
    always_ff @(posedge ref_clk) begin
        detect_done <= (dly == 4'h1);
        dly <= detect_start ? 4'h4 : (dly != 4'h0 ? dly - 4'h1 : 4'h0);
        ph <= (ph + 1) % (100 * MS_DIV);
    end
    // Result is not valid outside done, so show the inverse
    assign detect_result = detect_done ? sig : ~sig;
    // 5 ms pulse every 100 ms
    assign load_pulse = mps_on && (ph < 5 * MS_DIV);
endmodule
`default_nettype wire

// ### bench/pps_sequencer_chk.sv
/* Checker for the sequencer ports.
   Assumes one clock domain with rst as async reset. */
`default_nettype none
module pps_sequencer_chk #(parameter int MS_DIV = 10) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reset_in_n,
    input wire logic at_limit,
    input wire logic detect_start,
    input wire logic gate_enable,
    input wire logic gate_regulate,
    input wire logic powered_led_o,
    input wire logic powered_led_oe,
    input wire logic port_powered,
    input wire logic fault_event,
    input wire logic disconnect_event,
    input wire logic [2:0] level_latched
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [7:0] lo_cnt; // Consecutive low cycles of the pin
    logic [2:0] hi_cnt; // Consecutive high cycles of the pin
    int since; // Cycles since power was removed
    logic armed; // A retry is pending
    // Helper counters
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lo_cnt <= 8'h00;
            hi_cnt <= 3'h0;
            since <= 0;
            armed <= 1'b0;
        end else begin
            lo_cnt <= reset_in_n ? 8'h00 : (lo_cnt == 8'hff ? lo_cnt : lo_cnt + 8'h01);
            hi_cnt <= !reset_in_n ? 3'h0 : (hi_cnt == 3'h7 ? hi_cnt : hi_cnt + 3'h1);
            since <= (fault_event || disconnect_event) ? 0 : since + 1;
            armed <= (fault_event || disconnect_event) || (armed && !detect_start && reset_in_n);
        end
    end
    sequence s_off;
        !gate_enable ##1 !detect_start [*8];
    endsequence
    property p_led;
        powered_led_oe == port_powered && powered_led_o == 1'b0;
    endproperty
    a_led: assert property (p_led) else $error("led mismatch");
    property p_held;
        lo_cnt >= 8'h73 |-> !port_powered && !gate_enable;
    endproperty
    a_held: assert property (p_held) else $error("power on in reset");
    property p_reg;
        gate_regulate == (gate_enable && at_limit);
    endproperty
    a_reg: assert property (p_reg) else $error("regulate wrong");
    property p_fault;
        fault_event |-> s_off;
    endproperty
    a_fault: assert property (p_fault) else $error("gate kept on");
    property p_disc;
        disconnect_event |-> !port_powered ##1 !port_powered;
    endproperty
    a_disc: assert property (p_disc) else $error("power kept on");
    property p_retry;
        detect_start && armed |-> since >= 1298 * MS_DIV && since <= 1302 * MS_DIV;
    endproperty
    a_retry: assert property (p_retry) else $error("retry delay wrong");
    property p_latch;
        hi_cnt >= 3'h4 |-> $stable(level_latched);
    endproperty
    a_latch: assert property (p_latch) else $error("level changed");
    property p_pulse;
        fault_event || disconnect_event |=> !fault_event && !disconnect_event;
    endproperty
    a_pulse: assert property (p_pulse) else $error("event too long");
endmodule
bind pps_sequencer pps_sequencer_chk #(.MS_DIV(MS_DIV)) chk_u (.ref_clk(ref_clk), .rst(rst),
    .reset_in_n(reset_in_n), .at_limit(at_limit), .detect_start(detect_start),
    .gate_enable(gate_enable), .gate_regulate(gate_regulate), .powered_led_o(powered_led_o),
    .powered_led_oe(powered_led_oe), .port_powered(port_powered), .fault_event(fault_event),
    .disconnect_event(disconnect_event), .level_latched(level_latched));
`default_nettype wire

// ### bench/pps_sequencer_tb.sv
/* Self-checking bench for the sequencer.
   Assumes MS_DIV of 10 so 1 ms is 10 cycles. */
`default_nettype none
module pps_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst = 1'b1, rin_n = 1'b1, oc = 1'b0, lim = 1'b0, ext = 1'b0;
    logic mps = 1'b1, pre = 1'b0, tw = 1'b1, done, lp, ds, ge, gr, lo, oe, pp, fe, de, ta;
    logic [2:0] sig = pps_pkg::DET_GOOD, res, lvl = 3'h5, al, ll;
    int failures = 0, n_compared = 0, n_f = 0, n_d = 0;
    always #20 ref_clk = ~ref_clk;
    // Count event pulses mid-cycle, where the registered outputs have settled
    always @(negedge ref_clk) begin
        n_f += (fe === 1'b1);
        n_d += (de === 1'b1);
    end
    pps_sequencer #(.MS_DIV(10)) dut_u (.ref_clk(ref_clk), .rst(rst), .reset_in_n(rin_n),
        .injector_select(1'b0), .prestandard_select(pre), .twin_signature_select(tw),
        .power_level_setting(lvl), .detect_done(done), .detect_result(res),
        .twin_detected(tw), .pd_class(3'h0), .class_extended(ext), .over_cut(oc),
        .at_limit(lim), .load_pulse(lp), .detect_start(ds), .gate_enable(ge),
        .gate_regulate(gr), .powered_led_o(lo), .powered_led_oe(oe), .port_powered(pp),
        .fault_event(fe), .disconnect_event(de), .allocated_level(al), .twin_active(ta),
        .level_latched(ll));
    pps_pd_model #(.MS_DIV(10)) pd_u (.ref_clk(ref_clk), .detect_start(ds), .sig(sig),
        .mps_on(mps), .detect_done(done), .detect_result(res), .load_pulse(lp));
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Bounded wait for the power level
    task wait_pow(input logic e, input int m);
        for (int i = 0; i < m && pp !== e; i++) tick(1);
        chk(pp, e);
    endtask
    task results;
        if (failures == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #1400000;
        failures++;
        results;
    end
    initial begin
        tick(4);
        rst = 1'b0;
        tick(3);
        lvl = 3'h2;
        chk(ll, 3'h5);
        wait_pow(1'b1, 200);
        chk(oe, 1'b1);
        chk(ta, 1'b1);
        rin_n = 1'b0;
        tick(50);
        rin_n = 1'b1;
        tick(5);
        chk(pp, 1'b1);
        tick(5000);
        chk(pp, 1'b1);
        mps = 1'b0;
        wait_pow(1'b0, 4000);
        tick(1);
        chk(n_d[7:0], 8'h01);
        mps = 1'b1;
        wait_pow(1'b1, 14000);
        oc = 1'b1;
        wait_pow(1'b0, 700);
        tick(1);
        chk(n_f[7:0], 8'h01);
        oc = 1'b0;
        rin_n = 1'b0;
        tick(200);
        chk(pp, 1'b0);
        sig = pps_pkg::DET_RES_LOW;
        rin_n = 1'b1;
        tick(5);
        pre = 1'b1;
        tick(295);
        chk(ll, 3'h2);
        chk(pp, 1'b0);
        sig = pps_pkg::DET_GOOD;
        wait_pow(1'b1, 100);
        chk(al, 3'h2);
        chk(ta, 1'b0);
        ext = 1'b1;
        tick(1);
        lim = 1'b1;
        wait_pow(1'b0, 130);
        tick(1);
        chk(n_f[7:0], 8'h02);
        lim = 1'b0;
        ext = 1'b0;
        rin_n = 1'b0;
        sig = pps_pkg::DET_RES_LOW;
        tick(200);
        rin_n = 1'b1;
        wait_pow(1'b1, 100);
        chk(al, pps_pkg::PWR_13W);
        rin_n = 1'b0;
        tick(120);
        chk(pp, 1'b0);
        results;
    end
endmodule
`default_nettype wire
